/* File: rtl/pll_device.sv */
// dual synthesizer digital section: serial latches, dividers, phase detector, lock, status mux
// How it works
// - feedback ratio is modulus times main plus swallow
// - each section selects 8/9, 16/17, 32/33, 64/65
// - prescaler built on a 4/5 core
// - software keeps prescaler output within rated speed
// - main count accepts 3 to 8191
// - swallow count is 6 bits, 0 to 63
// - reference divider ratio 1 to 32767
// - phase detector compares reference and feedback edges
// - four latch bits select the status output
// - digital lock after three errors below 15 ns
// - digital lock drops on error above 25 ns
// - analog lock open drain, high with low pulses
// - one data bit shifted per serial clock rise
// - host sends most significant bit first
// - load strobe rise copies shift register to latch
// - two lowest word bits choose the latch
// - latch codes: IF ref, IF AB, RF ref, RF AB
// - separate reference and feedback counters per section
`timescale 1ns/1ns
module pll_device
  import pll_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  pll_serial_if.device link,
  input wire logic ref_in,
  input wire logic rf_in,
  input wire logic if_in,
  output logic [1:0] pd_up,
  output logic [1:0] pd_down,
  output logic [1:0] lock_flag,
  output logic status_out,
  output logic status_oe
);

  // ==================================================
  // pin synchronisers and edge detection
  localparam int NPIN = 6;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1_q;
  logic [NPIN-1:0] sync2_q;
  logic [NPIN-1:0] prev_q;
  logic [NPIN-1:0] rise;

  assign pin_raw = {if_in, rf_in, ref_in, link.load_strobe, link.sdata, link.sclk};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  assign rise = sync2_q & ~prev_q;

  logic sclk_rise;
  logic load_rise;
  logic ref_rise;
  logic [1:0] fb_rise;

  assign sclk_rise = rise[0];
  assign load_rise = rise[2];
  assign ref_rise = rise[3];
  assign fb_rise = {rise[4], rise[5]};

  // ==================================================
  // serial shift register and latches
  logic [WORD_W-1:0] shift_q;
  logic [WORD_W-1:0] r_latch_q [2];
  logic [WORD_W-1:0] ab_latch_q [2];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_q <= '0;
    end else if (sclk_rise) begin
      shift_q <= {shift_q[WORD_W-2:0], sync2_q[1]};
    end
  end

  // latches move only on the strobe, never while bits shift
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_latch_q[0] <= LATCH_RESET;
      r_latch_q[1] <= LATCH_RESET;
      ab_latch_q[0] <= LATCH_RESET;
      ab_latch_q[1] <= LATCH_RESET;
    end else if (load_rise) begin
      case (shift_q[1:0])
        SEL_IF_R: r_latch_q[0] <= shift_q;
        SEL_IF_AB: ab_latch_q[0] <= shift_q;
        SEL_RF_R: r_latch_q[1] <= shift_q;
        SEL_RF_AB: ab_latch_q[1] <= shift_q;
        default: r_latch_q[0] <= r_latch_q[0];
      endcase
    end
  end

  // ==================================================
  // helpers
  function automatic logic [R_W-1:0] r_ratio(input logic [WORD_W-1:0] w);
    logic [R_W-1:0] r;
    r = w[R_LSB +: R_W];
    return (r < R_MIN) ? R_MIN : r;
  endfunction

  function automatic logic [B_W-1:0] b_ratio(input logic [WORD_W-1:0] w);
    logic [B_W-1:0] b;
    b = w[B_LSB +: B_W];
    return (b < B_MIN) ? B_MIN : b;
  endfunction

  function automatic logic [31:0] err_ns(input logic [ERR_W-1:0] c);
    return {16'h0000, c} * CLK_PERIOD_NS;
  endfunction

  logic [1:0] ndiv_q;
  logic [1:0] rdiv_q;
  logic [1:0] alock;

  // ==================================================
  // per-section dividers, phase detector and lock detect (0 = IF, 1 = RF)
  genvar s;
  generate
    for (s = 0; s < 2; s++) begin : g_sec
      logic [2:0] core_q;
      logic [3:0] ext_q;
      logic [3:0] ext_last;
      logic swallow;
      logic core_end;
      logic presc_pulse;
      logic [A_W-1:0] a_cnt_q;
      logic [B_W-1:0] b_cnt_q;
      logic [R_W-1:0] r_cnt_q;
      logic n_pulse_q;
      logic r_pulse_q;
      logic up_q;
      logic dn_q;
      logic ref_arm;
      logic fb_arm;
      logic [ERR_W-1:0] err_q;
      logic [1:0] run_q;
      logic lock_q;
      logic pol;
      logic ndiv_s_q;
      logic rdiv_s_q;

      // extension divides the 4/5 core by 2, 4, 8 or 16
      assign ext_last = 4'((5'h02 << ab_latch_q[s][PRE_LSB +: 2]) - 5'h01);
      assign swallow = (a_cnt_q != '0) && (ext_q == ext_last);
      assign core_end = (core_q == (swallow ? 3'h4 : 3'h3));
      assign presc_pulse = fb_rise[s] && core_end && (ext_q == ext_last);

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          core_q <= '0;
          ext_q <= '0;
        end else if (fb_rise[s]) begin
          if (core_end) begin
            core_q <= '0;
            ext_q <= (ext_q == ext_last) ? 4'h0 : 4'(ext_q + 4'h1);
          end else begin
            core_q <= 3'(core_q + 3'h1);
          end
        end
      end

      // swallow count runs A cycles at P+1, main count B cycles in all
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          a_cnt_q <= '0;
          b_cnt_q <= '0;
          n_pulse_q <= 1'b0;
        end else begin
          n_pulse_q <= 1'b0;
          if (presc_pulse) begin
            if (b_cnt_q <= 13'h0001) begin
              b_cnt_q <= b_ratio(ab_latch_q[s]);
              a_cnt_q <= ab_latch_q[s][A_LSB +: A_W];
              n_pulse_q <= 1'b1;
            end else begin
              b_cnt_q <= 13'(b_cnt_q - 13'h0001);
              if (a_cnt_q != '0) begin
                a_cnt_q <= 6'(a_cnt_q - 6'h01);
              end
            end
          end
        end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          r_cnt_q <= '0;
          r_pulse_q <= 1'b0;
        end else begin
          r_pulse_q <= 1'b0;
          if (ref_rise) begin
            if (r_cnt_q >= 15'(r_ratio(r_latch_q[s]) - R_MIN)) begin
              r_cnt_q <= '0;
              r_pulse_q <= 1'b1;
            end else begin
              r_cnt_q <= 15'(r_cnt_q + 15'h0001);
            end
          end
        end
      end

      // phase/frequency detector: both armed resets both
      assign ref_arm = up_q | r_pulse_q;
      assign fb_arm = dn_q | n_pulse_q;

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          up_q <= 1'b0;
          dn_q <= 1'b0;
          err_q <= '0;
        end else if (ref_arm && fb_arm) begin
          up_q <= 1'b0;
          dn_q <= 1'b0;
          err_q <= '0;
        end else begin
          up_q <= ref_arm;
          dn_q <= fb_arm;
          if ((ref_arm || fb_arm) && err_q != '1) begin
            err_q <= 16'(err_q + 16'h0001);
          end
        end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          run_q <= '0;
          lock_q <= 1'b0;
        end else if (ref_arm && fb_arm) begin
          if (err_ns(err_q) < LOCK_ERR_NS) begin
            if (run_q == 2'(LOCK_RUN - 2'h1)) begin
              lock_q <= 1'b1;
            end
            if (run_q != LOCK_RUN) begin
              run_q <= 2'(run_q + 2'h1);
            end
          end else begin
            run_q <= '0;
            if (err_ns(err_q) > UNLOCK_ERR_NS) begin
              lock_q <= 1'b0;
            end
          end
        end
      end

      assign pol = r_latch_q[s][PD_POL_BIT];
      assign pd_up[s] = pol ? up_q : dn_q;
      assign pd_down[s] = pol ? dn_q : up_q;
      assign lock_flag[s] = lock_q;
      assign alock[s] = ~(up_q | dn_q);

      // one register per section keeps each divided output to a single process
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          ndiv_s_q <= 1'b0;
          rdiv_s_q <= 1'b0;
        end else begin
          if (n_pulse_q) begin
            ndiv_s_q <= ~ndiv_s_q;
          end
          if (r_pulse_q) begin
            rdiv_s_q <= ~rdiv_s_q;
          end
        end
      end

      assign ndiv_q[s] = ndiv_s_q;
      assign rdiv_q[s] = rdiv_s_q;
    end
  endgenerate

  // ==================================================
  // status output multiplexer
  logic [3:0] osel;
  logic mux_val;
  logic mux_oe;

  assign osel = {r_latch_q[1][OSEL_HI_BIT], r_latch_q[1][OSEL_LO_BIT],
                 r_latch_q[0][OSEL_HI_BIT], r_latch_q[0][OSEL_LO_BIT]};

  always_comb begin
    mux_val = 1'b0;
    mux_oe = 1'b1;
    case (osel)
      MUX_IF_DLOCK: mux_val = lock_flag[0];
      MUX_IF_NDIV: mux_val = ndiv_q[0];
      MUX_IF_ALOCK: mux_oe = ~alock[0];
      MUX_IF_RDIV: mux_val = rdiv_q[0];
      MUX_RF_DLOCK: mux_val = lock_flag[1];
      MUX_RF_NDIV: mux_val = ndiv_q[1];
      MUX_RF_ALOCK: mux_oe = ~alock[1];
      MUX_RF_RDIV: mux_val = rdiv_q[1];
      MUX_BOTH_DLOCK: mux_val = lock_flag[0] & lock_flag[1];
      MUX_LOW: mux_val = 1'b0;
      MUX_HIGH: mux_val = 1'b1;
      default: mux_oe = 1'b0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_out <= 1'b0;
      status_oe <= 1'b0;
    end else begin
      status_out <= mux_val;
      status_oe <= mux_oe;
    end
  end

endmodule

/* File: rtl/pll_pkg.sv */
// shared constants for the dual synthesizer serial load path and divider logic
package pll_pkg;
  // ==================================================
  // serial word and latch selection
  localparam int WORD_W = 24;
  localparam logic [1:0] SEL_IF_R = 2'h0;
  localparam logic [1:0] SEL_IF_AB = 2'h1;
  localparam logic [1:0] SEL_RF_R = 2'h2;
  localparam logic [1:0] SEL_RF_AB = 2'h3;
  localparam logic [WORD_W-1:0] LATCH_RESET = 24'h000000;

  // ==================================================
  // field positions of the reference latches
  localparam int R_LSB = 2;
  localparam int R_W = 15;
  localparam int PD_POL_BIT = 17;
  localparam int OSEL_LO_BIT = 19;
  localparam int OSEL_HI_BIT = 20;

  // ==================================================
  // field positions of the swallow/main latches
  localparam int A_LSB = 2;
  localparam int A_W = 6;
  localparam int B_LSB = 8;
  localparam int B_W = 13;
  localparam int PRE_LSB = 22;
  localparam logic [B_W-1:0] B_MIN = 13'h0003;
  localparam logic [R_W-1:0] R_MIN = 15'h0001;

  // ==================================================
  // lock detection timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int LOCK_ERR_NS = 15;
  localparam int UNLOCK_ERR_NS = 25;
  localparam logic [1:0] LOCK_RUN = 2'h3;
  localparam int ERR_W = 16;

  // ==================================================
  // status output selection codes
  localparam logic [3:0] MUX_OFF = 4'h0;
  localparam logic [3:0] MUX_IF_DLOCK = 4'h1;
  localparam logic [3:0] MUX_IF_NDIV = 4'h2;
  localparam logic [3:0] MUX_IF_ALOCK = 4'h3;
  localparam logic [3:0] MUX_IF_RDIV = 4'h4;
  localparam logic [3:0] MUX_RF_DLOCK = 4'h5;
  localparam logic [3:0] MUX_RF_NDIV = 4'h6;
  localparam logic [3:0] MUX_RF_ALOCK = 4'h7;
  localparam logic [3:0] MUX_RF_RDIV = 4'h8;
  localparam logic [3:0] MUX_BOTH_DLOCK = 4'h9;
  localparam logic [3:0] MUX_LOW = 4'hA;
  localparam logic [3:0] MUX_HIGH = 4'hB;

  // ==================================================
  // controller registers and serial timing
  localparam logic [31:0] ADDR_DATA = 32'h00000000;
  localparam logic [31:0] ADDR_CTRL = 32'h00000004;
  localparam logic [31:0] ADDR_STATUS = 32'h00000008;
  localparam int CTRL_START_BIT = 0;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int SCLK_HALF_DEF = 2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_LOW = 2'h1,
    ST_HIGH = 2'h3,
    ST_LOAD = 2'h2
  } host_state_e;
endpackage

/* File: rtl/pll_serial_if.sv */
// three-wire serial load link between controller and synthesizer
`timescale 1ns/1ns
interface pll_serial_if;
  logic sclk;
  logic sdata;
  logic load_strobe;
  modport device (input sclk, input sdata, input load_strobe);
  modport host (output sclk, output sdata, output load_strobe);
endinterface

/* File: rtl/pll_host.sv */
// serial load controller: AHB-Lite registers driving the three-wire link
`timescale 1ns/1ns
module pll_host
  import pll_pkg::*;
#(
  parameter int SCLK_HALF = SCLK_HALF_DEF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  pll_serial_if.host link
);

  // ==================================================
  // bus slave
  logic wr_q;
  logic [31:0] addr_q;
  logic [WORD_W-1:0] data_q;
  logic start_q;
  logic wr_start;
  logic take;
  logic busy;
  host_state_e state_q;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign busy = (state_q != ST_IDLE) | start_q;
  assign wr_start = wr_q && addr_q == ADDR_CTRL && hwdata[CTRL_START_BIT];
  assign take = (state_q == ST_IDLE) && start_q;

  function automatic logic [31:0] read_mux(input logic [31:0] a);
    case (a)
      ADDR_DATA: return {8'h00, data_q};
      ADDR_STATUS: return {31'h00000000, busy} << STATUS_BUSY_BIT;
      default: return 32'h00000000;
    endcase
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      addr_q <= '0;
      hrdata <= '0;
    end else begin
      wr_q <= hsel && hready && htrans[1] && hwrite && hsize == 3'h2;
      if (hsel && hready && htrans[1]) begin
        addr_q <= haddr;
        if (!hwrite) begin
          hrdata <= read_mux(haddr);
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_q <= '0;
    end else if (wr_q && addr_q == ADDR_DATA) begin
      data_q <= hwdata[WORD_W-1:0];
    end
  end

  // a start written in the cycle it is taken still counts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_q <= 1'b0;
    end else begin
      start_q <= wr_start | (start_q & ~take);
    end
  end

  // ==================================================
  // serial sequencer
  logic [7:0] div_q;
  logic tick;
  logic [4:0] bit_q;
  logic [WORD_W-1:0] word_q;
  logic sclk_q;
  logic sdata_q;
  logic load_q;

  assign tick = (div_q == 8'(SCLK_HALF - 1));
  assign link.sclk = sclk_q;
  assign link.sdata = sdata_q;
  assign link.load_strobe = load_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= '0;
    end else if (state_q == ST_IDLE || tick) begin
      div_q <= '0;
    end else begin
      div_q <= 8'(div_q + 8'h01);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_IDLE;
      bit_q <= '0;
      word_q <= '0;
      sclk_q <= 1'b0;
      sdata_q <= 1'b0;
      load_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start_q) begin
            word_q <= data_q;
            bit_q <= 5'(WORD_W - 1);
            sdata_q <= data_q[WORD_W-1];
            state_q <= ST_LOW;
          end
        end
        ST_LOW: begin
          if (tick) begin
            sclk_q <= 1'b1;
            state_q <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (tick) begin
            sclk_q <= 1'b0;
            if (bit_q == 5'h00) begin
              load_q <= 1'b1;
              state_q <= ST_LOAD;
            end else begin
              bit_q <= 5'(bit_q - 5'h01);
              sdata_q <= word_q[bit_q - 5'h01];
              state_q <= ST_LOW;
            end
          end
        end
        ST_LOAD: begin
          if (tick) begin
            load_q <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

endmodule

/* File: dv/pll_link_props.sv */
// concurrent checks on the three-wire serial load link
`timescale 1ns/1ns
module pll_link_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic load_strobe
);
  // ==================================================
  // helper: serial clock rises seen since the last commit
  logic sclk_q;
  logic [5:0] rise_cnt_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rise_cnt_q <= 6'h00;
    end else if (load_strobe) begin
      rise_cnt_q <= 6'h00;
    end else if (sclk && !sclk_q) begin
      rise_cnt_q <= rise_cnt_q + 6'h01;
    end
  end

  // ==================================================
  // properties
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_high_pulse;
    sclk [*2] ##1 !sclk;
  endsequence
  sequence s_strobe_pulse;
    load_strobe [*2] ##1 !load_strobe;
  endsequence
  chk_high_width: assert property ($rose(sclk) |-> s_high_pulse)
    else $error("serial clock high time wrong");
  chk_low_width: assert property ($fell(sclk) |-> !sclk [*2])
    else $error("serial clock low time too short");
  chk_data_hold: assert property (sclk |-> $stable(sdata))
    else $error("serial data moved while clock high");
  chk_word_bits: assert property ($rose(load_strobe) |-> rise_cnt_q == 6'h18)
    else $error("commit not after exactly 24 bits");
  chk_strobe_width: assert property ($rose(load_strobe) |-> s_strobe_pulse)
    else $error("load strobe width wrong");
  chk_strobe_sclk: assert property (load_strobe |-> !sclk)
    else $error("serial clock high during load strobe");
  chk_strobe_gap: assert property ($fell(load_strobe) |-> !sclk [*2])
    else $error("serial clock rose right after strobe");
  chk_release_idle: assert property ($rose(hresetn) |-> !sclk && !load_strobe)
    else $error("link not idle after reset");
  cover property ($rose(load_strobe));
endmodule

/* File: dv/dual_pll_divider_and_serial_load_test.sv */
// self-checking bench: controller and synthesizer joined across the serial link
`timescale 1ns/1ns
module dual_pll_divider_and_serial_load_test
  import pll_pkg::*;
;
  typedef struct packed {logic [3:0] code; logic out; logic oe;} row_s;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  logic ref_in = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic [1:0] lock_flag;
  logic [1:0] pd_up;
  logic [1:0] pd_down;
  logic status_out;
  logic status_oe;
  logic [23:0] wire_word = 24'h000000;
  int wire_bits = 0;
  int err_total = 0;
  int comparisons = 0;
  logic pre;
  logic [31:0] rd;
  row_s rows [8] = '{'{4'h0, 1'b0, 1'b0}, '{4'hA, 1'b0, 1'b1}, '{4'hB, 1'b1, 1'b1},
    '{4'h1, 1'b0, 1'b1}, '{4'h5, 1'b0, 1'b1}, '{4'h9, 1'b0, 1'b1}, '{4'hC, 1'b0, 1'b0},
    '{4'h3, 1'b0, 1'b1}};

  always #25 hclk = ~hclk;
  always begin
    repeat (3) @(posedge hclk);
    ref_in <= ~ref_in;
  end

  pll_serial_if link ();
  pll_host pll_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .link(link));
  pll_device pll_device_inst (.hclk(hclk), .hresetn(hresetn), .link(link), .ref_in(ref_in),
    .rf_in(1'b0), .if_in(1'b0), .pd_up(pd_up), .pd_down(pd_down), .lock_flag(lock_flag),
    .status_out(status_out), .status_oe(status_oe));
  pll_link_props pll_link_props_inst (.hclk(hclk), .hresetn(hresetn), .sclk(link.sclk),
    .sdata(link.sdata), .load_strobe(link.load_strobe));

  // ==================================================
  // wire monitor: collects bits as the device would shift them
  always @(posedge link.sclk) begin
    wire_word = {wire_word[22:0], link.sdata};
    wire_bits = wire_bits + 1;
  end

  // ==================================================
  // compare and bus tasks
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t bit %b expected %b", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd,
    output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  // sends one word; p holds the status pin as the strobe rises
  task automatic send(input logic [23:0] w, output logic p);
    logic [31:0] r;
    wire_bits = 0;
    xfer(ADDR_DATA, 1'b1, {8'h00, w}, r);
    xfer(ADDR_CTRL, 1'b1, 32'h00000001, r);
    xfer(ADDR_STATUS, 1'b0, 32'h00000000, r);
    chk_bit(r[STATUS_BUSY_BIT], 1'b1);
    @(posedge link.load_strobe);
    p = status_out;
    chk_word({8'h00, wire_word}, {8'h00, w});
    chk_word(32'(wire_bits), 32'h00000018);
    @(negedge link.load_strobe);
    repeat (4) @(posedge hclk);
    xfer(ADDR_STATUS, 1'b0, 32'h00000000, r);
    chk_bit(r[STATUS_BUSY_BIT], 1'b0);
  endtask
  function automatic logic [23:0] ref_word(input logic [1:0] sel, input logic [1:0] os);
    ref_word = {3'h0, os, 2'h0, 15'h0005, sel};
  endfunction
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==================================================
  // main sequence
  initial begin
    repeat (10) @(posedge hclk);
    chk_bit(status_oe, 1'b0);
    chk_word({30'h0, lock_flag}, 32'h00000000);
    hresetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      send(ref_word(SEL_IF_R, rows[i].code[1:0]), pre);
      send(ref_word(SEL_RF_R, rows[i].code[3:2]), pre);
      chk_bit(status_out, rows[i].out);
      chk_bit(status_oe, rows[i].oe);
    end
    // reference pulses with no feedback: reference leads, polarity 0 routes it down
    chk_word({28'h0, pd_up, pd_down}, 32'h00000003);
    // feedback words must leave the reference latches alone
    send(ref_word(SEL_IF_R, 2'h3), pre);
    send(ref_word(SEL_RF_R, 2'h2), pre);
    // main count 8 not below swallow 2, prescaler 8/9
    send({2'h0, 1'b0, 13'h0008, 6'h02, SEL_IF_AB}, pre);
    send({2'h0, 1'b0, 13'h0008, 6'h02, SEL_RF_AB}, pre);
    chk_bit(status_out, 1'b1);
    // shifting a new word keeps the old setting until the commit
    send(ref_word(SEL_IF_R, 2'h2), pre);
    chk_bit(pre, 1'b1);
    chk_bit(status_out, 1'b0);
    chk_bit(status_oe, 1'b1);
    xfer(32'h0000000C, 1'b0, 32'h00000000, rd);
    chk_word(rd, 32'h00000000);
    xfer(ADDR_DATA, 1'b0, 32'h00000000, rd);
    chk_word(rd, {8'h00, ref_word(SEL_IF_R, 2'h2)});
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk_bit(status_oe, 1'b0);
    close_out;
  end

  initial begin
    #(20000 * 50);
    err_total++;
    close_out;
  end
endmodule
